//--- rtl/dtpb_bank.sv
// Purpose: Speed tuning parameter bank with special command word
// Assumes: Classic Wishbone slave, one-cycle registered ack
// Notes: Out-of-range writes are dropped; the previous value stays
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
module dtpb_bank
  import dtpb_pkg::*;
#(
  parameter int NUM_INPUTS = 8,
  parameter int DEB_UNIT_CYC = DTPB_DEB_UNIT_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Gain switching
  input wire logic gain_switch_cond,
  input wire logic [15:0] speed_gain_in,
  output logic [15:0] speed_gain_active,
  // Parameter and mode outputs
  output dtpb_tune_t tune_o,
  output dtpb_mode_t mode_o,
  // Digital inputs
  input wire logic [NUM_INPUTS-1:0] din_pins,
  output logic [NUM_INPUTS-1:0] din_filtered
);
  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (NUM_INPUTS < 1 || NUM_INPUTS > 32) begin : g_chk_n
    $error("NUM_INPUTS out of range");
  end
  // A one-cycle step would leave the tick stuck high
  if (DEB_UNIT_CYC < 2) begin : g_chk_d
    $error("DEB_UNIT_CYC must be at least 2");
  end

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic req; // Request in progress, not yet acked
  logic wr_lo; // Write strobe with low half enabled
  logic [15:0] wdata; // Write value
  logic [15:0] speed_rate_q; // Gain switching rate
  logic [15:0] integ_q; // Integral compensation
  logic [15:0] ffwd_q; // Feed-forward percent
  logic [15:0] special_q; // Command word
  logic [15:0] deb_q; // Debounce setting
  dtpb_mode_t mode_q; // Special modes

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_lo = req && wb_we_i && (wb_sel_i[1:0] == 2'b11);
  assign wdata = wb_dat_i[15:0];

  // Ack one cycle after the request, drop the next
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // ----------------------------------------
  // Parameter registers
  // ----------------------------------------
  // Switching rate, 10..500
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      speed_rate_q <= DTPB_RATE_RST;
    end else if (wr_lo && wb_adr_i == DTPB_SPEED_RATE_IDX &&
                 wdata >= DTPB_RATE_MIN && wdata <= DTPB_RATE_MAX) begin
      speed_rate_q <= wdata;
    end
  end

  // Integral compensation, 0..1023
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      integ_q <= DTPB_INTEG_RST;
    end else if (wr_lo && wb_adr_i == DTPB_INTEG_IDX && wdata <= DTPB_INTEG_MAX) begin
      integ_q <= wdata;
    end
  end

  // Feed-forward percent, 0..100
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ffwd_q <= DTPB_FFWD_RST;
    end else if (wr_lo && wb_adr_i == DTPB_FFWD_IDX && wdata <= DTPB_FFWD_MAX) begin
      ffwd_q <= wdata;
    end
  end

  // Debounce setting, 0..20
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      deb_q <= DTPB_DEBOUNCE_RST;
    end else if (wr_lo && wb_adr_i == DTPB_DEBOUNCE_IDX && wdata <= DTPB_DEBOUNCE_MAX) begin
      deb_q <= wdata;
    end
  end

  // Command word, full 16-bit range stored
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      special_q <= DTPB_SPECIAL_RST;
    end else if (wr_lo && wb_adr_i == DTPB_SPECIAL_IDX) begin
      special_q <= wdata;
    end
  end

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  logic cmd_wr; // Write to the command word
  assign cmd_wr = wr_lo && wb_adr_i == DTPB_SPECIAL_IDX;

  // Mode flags set by codes; held until reset, and the force flag also until the force-off code
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mode_q <= '0;
    end else if (cmd_wr) begin
      case (wdata)
        DTPB_CMD_RESTORE: begin
          mode_q.restore_pending <= 1'b1;
        end
        DTPB_CMD_UNLOCK_ONE: begin
          mode_q.unlock_single <= 1'b1;
        end
        DTPB_CMD_UNLOCK_GRP: begin
          mode_q.unlock_group <= 1'b1;
        end
        DTPB_CMD_FORCE_ON: begin
          mode_q.force_output <= 1'b1;
        end
        DTPB_CMD_FORCE_OFF: begin
          mode_q.force_output <= 1'b0;
        end
        default: begin
          mode_q <= mode_q;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Gain scaling
  // ----------------------------------------
  logic [31:0] prod; // Gain times rate
  logic [31:0] scaled; // Product over one hundred
  assign prod = 32'(speed_gain_in) * 32'(speed_rate_q);
  assign scaled = prod / 32'(DTPB_PERCENT);

  // Registered active gain
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      speed_gain_active <= 16'h0000;
    end else if (gain_switch_cond) begin
      speed_gain_active <= (scaled > 32'h0000ffff) ? 16'hffff : scaled[15:0];
    end else begin
      speed_gain_active <= speed_gain_in;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [15:0] status; // Mode flags as a word
  assign status = {12'h000, mode_q.force_output, mode_q.unlock_group,
                   mode_q.unlock_single, mode_q.restore_pending};

  // Registered read data, unmapped reads return zero
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wb_dat_o <= 32'h00000000;
    end else if (req) begin
      case (wb_adr_i)
        DTPB_SPEED_RATE_IDX: wb_dat_o <= {16'h0000, speed_rate_q};
        DTPB_INTEG_IDX: wb_dat_o <= {16'h0000, integ_q};
        DTPB_FFWD_IDX: wb_dat_o <= {16'h0000, ffwd_q};
        DTPB_SPECIAL_IDX: wb_dat_o <= {16'h0000, special_q};
        DTPB_DEBOUNCE_IDX: wb_dat_o <= {16'h0000, deb_q};
        DTPB_STATUS_IDX: wb_dat_o <= {16'h0000, status};
        DTPB_SPEED_IN_IDX: wb_dat_o <= {16'h0000, speed_gain_in};
        DTPB_SPEED_OUT_IDX: wb_dat_o <= {16'h0000, speed_gain_active};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  assign tune_o = '{speed_integral_comp: integ_q, speed_feedforward: ffwd_q,
                    debounce_time_setting: deb_q};
  assign mode_o = mode_q;

  // ----------------------------------------
  // Debounce timing
  // ----------------------------------------
  logic [31:0] div_q; // 2 ms divider
  logic tick_q; // One pulse per 2 ms
  logic [NUM_INPUTS-1:0] sync1_q; // First synchroniser stage
  logic [NUM_INPUTS-1:0] sync2_q; // Second synchroniser stage

  // Divider producing the 2 ms step
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      div_q <= 32'h00000000;
      tick_q <= 1'b0;
    end else if (div_q == 32'(DEB_UNIT_CYC - 1)) begin
      div_q <= 32'h00000000;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 32'h00000001;
      tick_q <= 1'b0;
    end
  end

  // Two-stage synchroniser for pins
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= din_pins;
      sync2_q <= sync1_q;
    end
  end

  for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_deb
    dtpb_debounce u_deb (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .tick(tick_q),
      .setting(deb_q),
      .din(sync2_q[i]),
      .dout(din_filtered[i])
    );
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_integ_range: assert property (@(posedge sys_clk) disable iff (sys_rst)
    integ_q <= DTPB_INTEG_MAX) else $error("Integral value out of range");

  a_ffwd_range: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ffwd_q <= DTPB_FFWD_MAX) else $error("Feed-forward out of range");

  a_integ_keep: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (wr_lo && wb_adr_i == DTPB_INTEG_IDX && wdata > DTPB_INTEG_MAX)
    |=> $stable(integ_q)) else $error("Bad integral write took effect");

  a_restore_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cmd_wr && wdata == DTPB_CMD_RESTORE) |=> mode_q.restore_pending)
    else $error("Restore not scheduled");

  a_unlock_one: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cmd_wr && wdata == DTPB_CMD_UNLOCK_ONE) |=> mode_q.unlock_single)
    else $error("Single unlock missing");

  a_unlock_grp: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cmd_wr && wdata == DTPB_CMD_UNLOCK_GRP) |=> mode_q.unlock_group)
    else $error("Group unlock missing");

  a_force_on: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cmd_wr && wdata == DTPB_CMD_FORCE_ON) |=> mode_q.force_output)
    else $error("Forced mode not entered");

  a_force_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cmd_wr && wdata == DTPB_CMD_FORCE_OFF) |=> !mode_q.force_output)
    else $error("Forced mode not left");

  a_other_code: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cmd_wr && wdata != DTPB_CMD_RESTORE && wdata != DTPB_CMD_UNLOCK_ONE &&
     wdata != DTPB_CMD_UNLOCK_GRP && wdata != DTPB_CMD_FORCE_ON &&
     wdata != DTPB_CMD_FORCE_OFF) |=> ($stable(mode_q) && special_q == $past(wdata)))
    else $error("Other code changed a mode");

  a_gain_scale: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!sys_rst && gain_switch_cond && scaled <= 32'h0000ffff)
    |=> speed_gain_active == $past(scaled[15:0]))
    else $error("Gain not scaled");

  a_tick_gap: assert property (@(posedge sys_clk) disable iff (sys_rst)
    tick_q |=> !tick_q) else $error("Debounce step too short");

  a_bus_ack: assert property (@(posedge sys_clk) disable iff (sys_rst)
    req |=> wb_ack_o ##1 !wb_ack_o) else $error("Ack not single cycle");
endmodule : dtpb_bank

//--- rtl/dtpb_debounce.sv
// Purpose: Debounce filter for one digital input
// Assumes: Input already synchronised; tick is a one-cycle pulse per 2 ms
// Notes: Output follows input after setting ticks of stable level
`timescale 1ns/1ps
module dtpb_debounce
  import dtpb_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Timing
  input wire logic tick,
  input wire logic [15:0] setting,
  // Data
  input wire logic din,
  output logic dout
);
  logic [15:0] cnt_q; // Stable tick count
  // ----------------------------------------
  // Filter
  // ----------------------------------------
  // Count ticks of a level that differs from the output
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_q <= 16'h0000;
      dout <= 1'b0;
    end else if (din == dout) begin
      cnt_q <= 16'h0000;
    end else if (setting == 16'h0000) begin
      dout <= din; // Zero setting: no filter
    end else if (tick) begin
      if (cnt_q + 16'h0001 >= setting) begin
        dout <= din;
        cnt_q <= 16'h0000;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end
endmodule : dtpb_debounce

//--- rtl/dtpb_pkg.sv
// Purpose: Constants and types for the drive tuning parameter bank
// Assumes: Wishbone byte addresses, 16-bit parameters in the low half of each word
// Notes: Shared by the bank and its debounce filter
package dtpb_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [11:0] DTPB_SPEED_RATE_IDX = 12'h20a; // Gain switching rate
  localparam logic [11:0] DTPB_INTEG_IDX = 12'h20c; // Integral compensation
  localparam logic [11:0] DTPB_FFWD_IDX = 12'h20e; // Feed-forward percent
  localparam logic [11:0] DTPB_SPECIAL_IDX = 12'h210; // Special command word
  localparam logic [11:0] DTPB_DEBOUNCE_IDX = 12'h212; // Debounce setting
  localparam logic [11:0] DTPB_STATUS_IDX = 12'h220; // Bank status
  localparam logic [11:0] DTPB_SPEED_IN_IDX = 12'h222; // Active speed gain input
  localparam logic [11:0] DTPB_SPEED_OUT_IDX = 12'h224; // Scaled speed gain result
  // ----------------------------------------
  // Reset values and ranges
  // ----------------------------------------
  localparam logic [15:0] DTPB_RATE_RST = 16'h0064;
  localparam logic [15:0] DTPB_RATE_MIN = 16'h000a;
  localparam logic [15:0] DTPB_RATE_MAX = 16'h01f4;
  localparam logic [15:0] DTPB_INTEG_RST = 16'h0064;
  localparam logic [15:0] DTPB_INTEG_MAX = 16'h03ff;
  localparam logic [15:0] DTPB_FFWD_RST = 16'h0000;
  localparam logic [15:0] DTPB_FFWD_MAX = 16'h0064;
  localparam logic [15:0] DTPB_SPECIAL_RST = 16'h0000;
  localparam logic [15:0] DTPB_DEBOUNCE_RST = 16'h0002;
  localparam logic [15:0] DTPB_DEBOUNCE_MAX = 16'h0014;
  localparam logic [15:0] DTPB_PERCENT = 16'h0064;
  // ----------------------------------------
  // Special command codes
  // ----------------------------------------
  localparam logic [15:0] DTPB_CMD_RESTORE = 16'h000a; // 10
  localparam logic [15:0] DTPB_CMD_UNLOCK_ONE = 16'h0014; // 20
  localparam logic [15:0] DTPB_CMD_UNLOCK_GRP = 16'h0016; // 22
  localparam logic [15:0] DTPB_CMD_FORCE_ON = 16'h0196; // 406
  localparam logic [15:0] DTPB_CMD_FORCE_OFF = 16'h0190; // 400
  // ----------------------------------------
  // Status bit positions
  // ----------------------------------------
  localparam int DTPB_ST_RESTORE = 0;
  localparam int DTPB_ST_UNLOCK_ONE = 1;
  localparam int DTPB_ST_UNLOCK_GRP = 2;
  localparam int DTPB_ST_FORCE = 3;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int DTPB_CLK_MHZ = 200;
  localparam int DTPB_DEB_UNIT_MS = 2; // One setting step in ms
  localparam int DTPB_DEB_UNIT_CYC = DTPB_DEB_UNIT_MS * DTPB_CLK_MHZ * 1000;
  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic restore_pending; // Factory restore at next power-up
    logic unlock_single; // Single protected parameter active
    logic unlock_group; // Nine-parameter group active
    logic force_output; // Forced output mode
  } dtpb_mode_t;
  typedef struct packed {
    logic [15:0] speed_integral_comp;
    logic [15:0] speed_feedforward;
    logic [15:0] debounce_time_setting;
  } dtpb_tune_t;
endpackage : dtpb_pkg

//--- verification/dtpb_host_model.sv
// Purpose: Host model that reaches the parameter bank over Wishbone
// Assumes: Classic single cycles, one request at a time
// Notes: Released address and data lines toggle so stale values are never trusted
`timescale 1ns/1ps
module dtpb_host_model (
  // Clock
  input wire logic sys_clk,
  // Wishbone master
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [11:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_i
);
  // ----------------------------------------
  // Idle bus at time zero
  // ----------------------------------------
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 12'h000;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0;
  end
  // ----------------------------------------
  // One cycle, held until ack is seen at an edge
  // ----------------------------------------
  task automatic xfer(input logic we, input logic [11:0] a, input logic [15:0] d,
                      input logic [3:0] sel, output logic [31:0] q);
    @(posedge sys_clk);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= we;
    wb_adr_o <= a;
    wb_sel_o <= sel;
    wb_dat_o <= {16'h0, d};
    @(posedge sys_clk);
    // Wait for ack; only the bench watchdog ends a hang
    while (wb_ack_i !== 1'b1) begin
      @(posedge sys_clk);
    end
    q = wb_dat_i;
    // Release; lines no longer carry the request
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o <= ~we;
    wb_adr_o <= ~a;
    wb_dat_o <= ~{16'h0, d};
  endtask : xfer
endmodule : dtpb_host_model

//--- verification/tb_top.sv
// Purpose: Self-checking bench for the tuning parameter bank
// Assumes: Short debounce tick so filter delays stay small
// Notes: Reset values and table rows first, then gain, filter and reset cases
`timescale 1ns/1ps
module tb_top;
  import dtpb_pkg::*;
  // ----------------------------------------
  // Bench settings and signals
  // ----------------------------------------
  localparam int NIN = 8; // Input count
  localparam int UNIT = 4; // Cycles per debounce step
  typedef struct packed {
    logic [11:0] a; // Address
    logic [15:0] w; // Written value
    logic [15:0] e; // Expected readback
    logic [3:0] st; // Expected status
  } dtpb_row_t;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wb_cyc, wb_stb, wb_we, wb_ack;
  logic [11:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_wdat, wb_rdat, q;
  logic gain_switch_cond = 1'b0;
  logic [15:0] speed_gain_in = 16'h0;
  logic [15:0] speed_gain_active;
  dtpb_tune_t tune_o;
  dtpb_mode_t mode_o;
  logic [NIN-1:0] din_pins = '0;
  logic [NIN-1:0] din_filtered;
  int errors = 0;
  int check_count = 0;
  int n;
  logic [11:0] ra [6] = '{12'h20a, 12'h20c, 12'h20e, 12'h210, 12'h212, 12'h220};
  logic [15:0] re [6] = '{16'h0064, 16'h0064, 16'h0000, 16'h0000, 16'h0002, 16'h0000};
  dtpb_row_t rows [16] = '{
    '{12'h20c, 16'h03ff, 16'h03ff, 4'h0}, // Top of integral range
    '{12'h20c, 16'h0400, 16'h03ff, 4'h0}, // Above range, kept
    '{12'h20c, 16'h0000, 16'h0000, 4'h0},
    '{12'h20e, 16'h0064, 16'h0064, 4'h0}, // Full percent
    '{12'h20e, 16'h0065, 16'h0064, 4'h0},
    '{12'h212, 16'h0014, 16'h0014, 4'h0},
    '{12'h212, 16'h0015, 16'h0014, 4'h0},
    '{12'h20a, 16'h0009, 16'h0064, 4'h0}, // Rate below range
    '{12'h20a, 16'h01f5, 16'h0064, 4'h0},
    '{12'h210, 16'h1234, 16'h1234, 4'h0}, // Plain value only stored
    '{12'h210, 16'h000a, 16'h000a, 4'h1}, // Restore flagged
    '{12'h210, 16'h0014, 16'h0014, 4'h3},
    '{12'h210, 16'h0016, 16'h0016, 4'h7},
    '{12'h210, 16'h0196, 16'h0196, 4'hf},
    '{12'h210, 16'h0190, 16'h0190, 4'h7}, // Force cleared only
    '{12'h300, 16'h0055, 16'h0000, 4'h7}}; // Unmapped
  // ----------------------------------------
  // Clock, design and host
  // ----------------------------------------
  always #2.5 sys_clk = ~sys_clk;
  dtpb_bank #(.NUM_INPUTS(NIN), .DEB_UNIT_CYC(UNIT)) dut_u (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .gain_switch_cond(gain_switch_cond),
    .speed_gain_in(speed_gain_in), .speed_gain_active(speed_gain_active),
    .tune_o(tune_o), .mode_o(mode_o), .din_pins(din_pins), .din_filtered(din_filtered));
  dtpb_host_model host_u (
    .sys_clk(sys_clk), .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb), .wb_we_o(wb_we),
    .wb_adr_o(wb_adr), .wb_sel_o(wb_sel), .wb_dat_o(wb_wdat), .wb_dat_i(wb_rdat),
    .wb_ack_i(wb_ack));
  // ----------------------------------------
  // Compare and verdict
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict();
    if (errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  // Drives one gain input and checks the result
  task automatic gain(input logic c, input logic [15:0] g, input logic [15:0] e);
    @(posedge sys_clk);
    gain_switch_cond <= c;
    speed_gain_in <= g;
    repeat (3) @(posedge sys_clk);
    chk({16'h0, speed_gain_active}, {16'h0, e});
  endtask : gain
  // Watchdog well past the expected run
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    print_verdict();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    // Reset values
    for (int i = 0; i < 6; i++) begin
      host_u.xfer(1'b0, ra[i], 16'h0, 4'hf, q);
      chk(q, {16'h0, re[i]});
    end
    chk({16'h0, tune_o.debounce_time_setting}, 32'h2);
    // Table of writes with readback and status
    foreach (rows[i]) begin
      host_u.xfer(1'b1, rows[i].a, rows[i].w, 4'hf, q);
      host_u.xfer(1'b0, rows[i].a, 16'h0, 4'hf, q);
      chk(q, {16'h0, rows[i].e});
      host_u.xfer(1'b0, DTPB_STATUS_IDX, 16'h0, 4'hf, q);
      chk(q, {28'h0, rows[i].st});
    end
    chk({28'h0, mode_o}, 32'he);
    chk({16'h0, tune_o.speed_integral_comp}, 32'h0);
    // Write without low byte enables is dropped
    host_u.xfer(1'b1, DTPB_FFWD_IDX, 16'h0032, 4'hc, q);
    host_u.xfer(1'b0, DTPB_FFWD_IDX, 16'h0, 4'hf, q);
    chk(q, 32'h64);
    chk({16'h0, tune_o.speed_feedforward}, 32'h64);
    // Gain scaling, bypass and saturation
    host_u.xfer(1'b1, DTPB_SPEED_RATE_IDX, 16'h00c8, 4'hf, q);
    gain(1'b1, 16'h0100, 16'h0200);
    gain(1'b0, 16'h0100, 16'h0100);
    host_u.xfer(1'b1, DTPB_SPEED_RATE_IDX, 16'h01f4, 4'hf, q);
    gain(1'b1, 16'hffff, 16'hffff);
    gain(1'b1, 16'h0010, 16'h0050);
    // Gain input and scaled result read back over the bus
    host_u.xfer(1'b0, DTPB_SPEED_IN_IDX, 16'h0, 4'hf, q);
    chk(q, 32'h10);
    host_u.xfer(1'b0, DTPB_SPEED_OUT_IDX, 16'h0, 4'hf, q);
    chk(q, 32'h50);
    // Filter delay: two sync stages, then four steps of four cycles
    host_u.xfer(1'b1, DTPB_DEBOUNCE_IDX, 16'h0004, 4'hf, q);
    @(posedge sys_clk);
    din_pins <= 8'ha5;
    n = 0;
    while (din_filtered !== 8'ha5 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    chk({31'h0, (n >= 15 && n <= 20)}, 32'h1);
    // One-cycle glitch must never reach the filtered outputs
    din_pins <= 8'h00;
    @(posedge sys_clk);
    din_pins <= 8'ha5;
    n = 0;
    repeat (30) begin
      @(posedge sys_clk);
      if (din_filtered !== 8'ha5) n++;
    end
    chk(n, 0);
    // Zero setting passes the synchronised level straight through
    host_u.xfer(1'b1, DTPB_DEBOUNCE_IDX, 16'h0000, 4'hf, q);
    @(posedge sys_clk);
    din_pins <= 8'h3c;
    repeat (4) @(posedge sys_clk);
    chk({24'h0, din_filtered}, 32'h3c);
    // Second reset in mid-run clears command and modes
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    host_u.xfer(1'b0, DTPB_SPECIAL_IDX, 16'h0, 4'hf, q);
    chk(q, 32'h0);
    chk({28'h0, mode_o}, 32'h0);
    print_verdict();
  end
endmodule : tb_top
